//--- logic/bgd_pkg.sv
// Purpose: Shared constants and types of the power stage controller.
// Assumes: One clock at 20 MHz; all times are converted to cycles here.
// Notes:   The counter width covers the longest wait used by the controller.
`default_nettype none

package bgd_pkg;

	// ==========================================================
	// Clock and conversion
	localparam int unsigned CLK_PERIOD_NS = 50;

	// Least times round up, and no wait is shorter than one cycle.
	function automatic int unsigned cyc_up(input int unsigned t_ns);
		int unsigned c;
		c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c == 0) ? 1 : c;
	endfunction

	// ==========================================================
	// Power stage timing
	localparam int unsigned T_TS_HOLDOFF_NS = 150;
	localparam int unsigned T_TS_EXIT_NS    = 45;
	localparam int unsigned T_SHUTDOWN_NS   = 2500;
	localparam int unsigned T_ENABLE_NS     = 5000;

	localparam int unsigned CNT_W = 8;
	typedef logic [CNT_W-1:0] bgd_cnt_t;

	localparam bgd_cnt_t HOLDOFF_CNT  = bgd_cnt_t'(cyc_up(T_TS_HOLDOFF_NS));
	localparam bgd_cnt_t TS_EXIT_CNT  = bgd_cnt_t'(cyc_up(T_TS_EXIT_NS));
	localparam bgd_cnt_t SHUTDOWN_CNT = bgd_cnt_t'(cyc_up(T_SHUTDOWN_NS));
	localparam bgd_cnt_t ENABLE_CNT   = bgd_cnt_t'(cyc_up(T_ENABLE_NS));

	// ==========================================================
	// Pulse generator
	localparam int unsigned DUTY_W = 8;
	typedef logic [DUTY_W-1:0] bgd_duty_t;
	// 200 cycles give a 100 kHz switching period.
	localparam bgd_duty_t PWM_PERIOD      = 8'hC8;
	localparam bgd_duty_t PWM_LAST        = 8'hC7;
	// Switching periods per soft-start duty step.
	localparam bgd_duty_t SS_STEP_PERIODS = 8'h04;
	localparam bgd_duty_t DUTY_ONE        = 8'h01;
	localparam bgd_cnt_t  CNT_ONE         = 8'h01;

	// ==========================================================
	// Controller states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_ENTER,
		ST_WAKE,
		ST_RUN,
		ST_PARK,
		ST_EXIT
	} bgd_state_e;

endpackage

`default_nettype wire

//--- logic/bgd_pwm.sv
// Purpose: Switching-period pulse generator with soft-start duty ramp.
// Assumes: run and duty_tgt come from logic on the same clock.
// Notes:   Duty is in cycles of a fixed period and clamps at the period.
`default_nettype none

module bgd_pwm
	import bgd_pkg::*;
(
	// Clock and reset
	input  wire logic      clk,
	input  wire logic      rst_n,
	// Control
	input  wire logic      run,
	input  wire bgd_duty_t duty_tgt,
	// Result
	output var  logic      pwm_hi,
	output var  bgd_duty_t duty_cur
);

	bgd_duty_t per_q;
	bgd_duty_t step_q;
	bgd_duty_t duty_q;
	logic      hi_q;

	wire bgd_duty_t tgt_c    = (duty_tgt > PWM_PERIOD) ? PWM_PERIOD : duty_tgt;
	wire logic      wrap     = (per_q == PWM_LAST);
	wire logic      step_end = wrap && (step_q == SS_STEP_PERIODS - DUTY_ONE);

	// ==========================================================
	// Period counter and ramp
	// A drop in target is taken at once; only rising duty is ramped,
	// since in-rush only occurs while the output is charging.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			per_q  <= '0;
			step_q <= '0;
			duty_q <= '0;
		end else if (!run) begin
			per_q  <= '0;
			step_q <= '0;
			duty_q <= '0;
		end else begin
			per_q  <= wrap ? '0 : per_q + DUTY_ONE;
			step_q <= step_end ? '0 : (wrap ? step_q + DUTY_ONE : step_q);
			if (tgt_c < duty_q)
				duty_q <= tgt_c;
			else if (step_end && duty_q < tgt_c)
				duty_q <= duty_q + DUTY_ONE;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			hi_q <= 1'b0;
		else
			hi_q <= run && (per_q < duty_q);
	end

	assign pwm_hi   = hi_q;
	assign duty_cur = duty_q;

endmodule

`default_nettype wire

//--- logic/bgd_ctrl.sv
// Purpose: Controller that drives a buck power stage through its three-level
//          pulse-width pin and three-level mode-select pin.
// Assumes: Pins are split into level and drive enable; SUPPLY_OK and
//          OVERCURRENT are asynchronous pins; EN, CONTINUOUS_MODE and DUTY
//          come from logic on the same clock.
// Notes:   A released pin (enable low) is the high-impedance level.
//
// Contract
// - Controller applies device supply before driving pulses on PWM.
// - Releasing mode-select to tri-state re-enters shutdown after 2.5 us.
// - Controller ramps duty through a soft start at power-up.
// - Controller does all monitoring and protection beyond lockout.
`default_nettype none

module bgd_ctrl
	import bgd_pkg::*;
(
	// Clock and reset
	input  wire logic      CLK,
	input  wire logic      RST_N,
	// User command port
	input  wire logic      EN,
	input  wire logic      CONTINUOUS_MODE,
	input  wire bgd_duty_t DUTY,
	// Monitoring pins
	input  wire logic      SUPPLY_OK,
	input  wire logic      OVERCURRENT,
	// Pulse-width pin
	output var  logic      PWM_O,
	output var  logic      PWM_OE,
	// Mode-select pin
	output var  logic      MODE_O,
	output var  logic      MODE_OE,
	// Status
	output var  logic      RUNNING,
	output var  logic      FAULT
);

	// ==========================================================
	// Pin synchronisers
	logic sup_s1_q;
	logic sup_s2_q;
	logic oc_s1_q;
	logic oc_s2_q;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sup_s1_q <= 1'b0;
			sup_s2_q <= 1'b0;
			oc_s1_q  <= 1'b0;
			oc_s2_q  <= 1'b0;
		end else begin
			sup_s1_q <= SUPPLY_OK;
			sup_s2_q <= sup_s1_q;
			oc_s1_q  <= OVERCURRENT;
			oc_s2_q  <= oc_s1_q;
		end
	end

	// ==========================================================
	// Sequencer state
	bgd_state_e state_q;
	bgd_state_e state_d;
	bgd_cnt_t   cnt_q;
	bgd_cnt_t   cnt_d;
	logic       fault_q;
	logic       pwm_o_q;
	logic       pwm_oe_q;
	logic       mode_o_q;
	logic       mode_oe_q;
	logic       run_q;
	logic       pwm_hi;
	bgd_duty_t  duty_cur;

	// overcurrent latch
	// Set wins over the clear, so a trip during EN low sets FAULT, but it clears again once OVERCURRENT falls.
	wire logic fault_d  = oc_s2_q || (fault_q && EN);
	wire logic stop     = !EN || !sup_s2_q || oc_s2_q || fault_q;
	wire logic cnt_done = (cnt_q == CNT_ONE);
	wire logic drive_md = (state_d != ST_OFF) && (state_d != ST_EXIT);

	always_comb begin
		state_d = state_q;
		cnt_d   = (cnt_q > CNT_ONE) ? cnt_q - CNT_ONE : cnt_q;
		unique case (state_q)
			ST_OFF: begin
				if (!stop) begin
					state_d = ST_ENTER;
					cnt_d   = ENABLE_CNT;
				end
			end
			ST_ENTER: begin
				if (stop) begin
					state_d = ST_EXIT;
					cnt_d   = SHUTDOWN_CNT;
				end else if (cnt_done) begin
					state_d = ST_WAKE;
					cnt_d   = TS_EXIT_CNT;
				end
			end
			ST_WAKE: begin
				if (stop) begin
					state_d = ST_PARK;
					cnt_d   = HOLDOFF_CNT;
				end else if (cnt_done)
					state_d = ST_RUN;
			end
			ST_RUN: begin
				if (stop) begin
					state_d = ST_PARK;
					cnt_d   = HOLDOFF_CNT;
				end
			end
			ST_PARK: begin
				if (cnt_done) begin
					state_d = ST_EXIT;
					cnt_d   = SHUTDOWN_CNT;
				end
			end
			ST_EXIT: begin
				if (cnt_done)
					state_d = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= ST_OFF;
			cnt_q   <= '0;
			fault_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			fault_q <= fault_d;
		end
	end

	// ==========================================================
	// Pin drive
	// PWM is driven low while waking so the stage sees a clean exit from
	// tri-state before the first pulse arrives.
	wire logic drive_pwm = (state_d == ST_WAKE) || (state_d == ST_RUN);
	wire logic pulse_on  = (state_d == ST_RUN);

	bgd_pwm u_pwm (
		.clk      (CLK),
		.rst_n    (RST_N),
		.run      (run_q),
		.duty_tgt (DUTY),
		.pwm_hi   (pwm_hi),
		.duty_cur (duty_cur)
	);

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pwm_o_q   <= 1'b0;
			pwm_oe_q  <= 1'b0;
			mode_o_q  <= 1'b0;
			mode_oe_q <= 1'b0;
			run_q     <= 1'b0;
		end else begin
			pwm_o_q   <= pulse_on && pwm_hi;
			pwm_oe_q  <= drive_pwm;
			mode_o_q  <= CONTINUOUS_MODE;
			mode_oe_q <= drive_md;
			run_q     <= pulse_on;
		end
	end

	assign PWM_O   = pwm_o_q;
	assign PWM_OE  = pwm_oe_q;
	assign MODE_O  = mode_o_q;
	assign MODE_OE = mode_oe_q;
	assign RUNNING = run_q;
	assign FAULT   = fault_q;

	// ==========================================================
	// Checks
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	supply_before_pulse_a: assert property (
		$rose(mode_oe_q) |-> $past(sup_s2_q)
	) else $error("Stage enabled without supply.");

	enable_wait_a: assert property (
		$rose(mode_oe_q) |-> !pwm_oe_q [*8]
	) else $error("PWM driven before enable delay.");

	release_quiet_a: assert property (
		$fell(mode_oe_q) |-> (!mode_oe_q && !pwm_oe_q) [*8]
	) else $error("Mode pin re-driven inside shutdown delay.");

	pwm_first_a: assert property (
		$fell(pwm_oe_q) |-> mode_oe_q ##1 mode_oe_q ##1 mode_oe_q
	) else $error("Mode pin released before PWM hold-off.");

	trip_stop_a: assert property (
		oc_s2_q |-> ##2 !RUNNING
	) else $error("Pulses continue after overcurrent.");

	ramp_step_a: assert property (
		duty_cur > $past(duty_cur) |-> duty_cur == $past(duty_cur) + DUTY_ONE
	) else $error("Soft start jumped more than one step.");

	ramp_start_a: assert property (
		$rose(run_q) |-> duty_cur == '0
	) else $error("Soft start did not begin from zero.");

	fault_hold_a: assert property (
		fault_q && EN |=> fault_q
	) else $error("Fault cleared while enabled.");

endmodule

`default_nettype wire

//--- dv/bgd_stage.sv
// Purpose: Behavioural power stage behind the two three-level pins.
// Assumes: Each pin arrives as a level and a drive enable; released is Hi-Z.
// Notes:   Gates are observed only; nothing feeds back to the controller.
`default_nettype none

module bgd_stage
(
	// Pins from the controller
	input  wire logic pwm_lvl,
	input  wire logic pwm_en,
	input  wire logic mode_lvl,
	input  wire logic mode_en,
	// Sensing
	input  wire logic zc_flag,
	input  wire logic vcc_ok,
	// Gates
	output wire logic hs_gate,
	output wire logic ls_gate
);
	timeunit 1ns;
	timeprecision 1ns;

	logic ls_hold  = 1'b0;
	wire  pwm_tri;
	wire  en_short;
	wire  en_long;
	wire  cont     = mode_en & mode_lvl;
	wire  stage_on = mode_lvl ? en_short : en_long;
	wire  run      = vcc_ok & stage_on & mode_en & !pwm_tri;

	// =========================================================
	// Pin decoding
	// Inertial delays swallow any release shorter than the delay, so a
	// glitch on a released PWM pin never reaches the gates; mode_en feeds run undelayed.
	// tri-state hold-off and exit
	assign #(150, 45) pwm_tri = !pwm_en;
	assign #(0, 2500) en_short = mode_en;
	assign #(5000, 2500) en_long = mode_en;

	// =========================================================
	// Gate drive
	// minimum on-time
	always @(negedge pwm_lvl) begin
		ls_hold = 1'b1;
		#350;
		wait (zc_flag || pwm_lvl);
		ls_hold = 1'b0;
	end
	assign hs_gate = run & pwm_lvl;
	assign ls_gate = run & !pwm_lvl & (cont | ls_hold);
endmodule

`default_nettype wire

//--- dv/tb_bgd_ctrl.sv
// Purpose: Self-checking bench for the power stage controller.
// Assumes: Inputs change on the rising edge, outputs are read on the falling.
// Notes:   Full documented counts are used; the run stays short.
`default_nettype none

`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
`define WAITV(s, v, lim) begin n = 0; \
	while ((s) !== (v) && n < (lim)) begin @(negedge clk); n++; end \
	if ((s) !== (v)) begin `CHK((s), (v)) stop_test(); end end
`define CNTHI(s, cyc) begin k = 0; \
	repeat (cyc) begin @(negedge clk); k += int'((s) === 1'b1); end end

module tb_bgd_ctrl
	import bgd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic      clk;
	logic      rst_n;
	logic      en;
	logic      cont_mode;
	bgd_duty_t duty;
	logic      sup_ok;
	logic      ovc;
	logic      zc;
	wire logic pwm_o;
	wire logic pwm_oe;
	wire logic mode_o;
	wire logic mode_oe;
	wire logic running;
	wire logic fault;
	wire logic hs;
	wire logic ls;
	int        n;
	int        k;
	int        n_fail;
	int        tests_run;

	bgd_ctrl DUT (.CLK(clk), .RST_N(rst_n), .EN(en),
		.CONTINUOUS_MODE(cont_mode), .DUTY(duty),
		.SUPPLY_OK(sup_ok), .OVERCURRENT(ovc), .PWM_O(pwm_o),
		.PWM_OE(pwm_oe), .MODE_O(mode_o), .MODE_OE(mode_oe),
		.RUNNING(running), .FAULT(fault));
	bgd_stage STAGE (.pwm_lvl(pwm_o), .pwm_en(pwm_oe), .mode_lvl(mode_o),
		.mode_en(mode_oe), .zc_flag(zc), .vcc_ok(sup_ok), .hs_gate(hs),
		.ls_gate(ls));

	always #25 clk = ~clk;

	task automatic stop_test();
		if (n_fail == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// =========================================================
	// Scenarios
	task automatic t_start(input logic mode, input int min_gap);
		@(posedge clk);
		en        <= 1'b1;
		cont_mode <= mode;
		`WAITV(mode_oe, 1'b1, 80)
		`CHK(n + 1 >= min_gap, 1'b1)
		`CHK(mode_o, mode)
		`WAITV(pwm_oe, 1'b1, 200)
		`CHK(n, int'(ENABLE_CNT))
		`CHK(pwm_o, 1'b0)
		@(negedge clk);
		`CHK(running, 1'b1)
		`CHK({hs, ls}, {1'b0, mode})
	endtask

	task automatic t_soft();
		// The first periods must carry no pulse at all.
		`CNTHI(pwm_o, 600)
		`CHK(k, 0)
		`WAITV(pwm_o, 1'b1, 400)
		`CHK({hs, ls}, 2'b10)
		// A lower target must take effect at once, with no ramp down.
		@(posedge clk);
		duty <= 8'h00;
		`CNTHI(pwm_o, 400)
		`CHK(k, 0)
		@(posedge clk);
		duty      <= 8'h05;
		cont_mode <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		`CHK(mode_o, 1'b0)
		@(posedge clk);
		cont_mode <= 1'b1;
	endtask

	task automatic t_stop();
		@(posedge clk);
		en <= 1'b0;
		`WAITV(pwm_oe, 1'b0, 4)
		`CHK({running, mode_oe}, 2'b01)
		`WAITV(mode_oe, 1'b0, 8)
		`CHK(n, int'(HOLDOFF_CNT))
		`CHK({hs, ls}, 2'b00)
	endtask

	task automatic t_supply();
		@(posedge clk);
		sup_ok <= 1'b0;
		`WAITV(running, 1'b0, 6)
		`CHK({hs, ls}, 2'b00)
		`WAITV(mode_oe, 1'b0, 8)
		`CNTHI(mode_oe, 100)
		`CHK(k, 0)
		@(posedge clk);
		sup_ok <= 1'b1;
	endtask

	task automatic t_fault();
		t_start(1'b1, 0);
		@(posedge clk);
		ovc <= 1'b1;
		`WAITV(fault, 1'b1, 6)
		@(posedge clk);
		ovc <= 1'b0;
		`WAITV(mode_oe, 1'b0, 10)
		`CNTHI(mode_oe, 100)
		`CHK(k, 0)
		`CHK(fault, 1'b1)
		@(posedge clk);
		en <= 1'b0;
		`WAITV(fault, 1'b0, 4)
	endtask

	initial begin
		clk       = 1'b0;
		rst_n     = 1'b0;
		en        = 1'b0;
		cont_mode = 1'b1;
		duty      = 8'h05;
		sup_ok    = 1'b1;
		ovc       = 1'b0;
		zc        = 1'b1;
		n_fail    = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		`CHK({pwm_oe, mode_oe, running, fault}, 4'h0)
		t_start(1'b1, 0);
		t_soft();
		t_stop();
		t_start(1'b0, int'(SHUTDOWN_CNT));
		t_supply();
		t_fault();
		stop_test();
	end
endmodule

`default_nettype wire
